// >>> rtl/sl8b_xcvr_top.sv
// serial link transceiver core: host port, queues, coder, serialiser
// assumes ref_clk_i is the bit clock; every tenth cycle is a character slot
// Overview of operation
// RL1: take one 8- or 10-bit character per write
// RL2: encode queued characters, shift out ten bits each
// RL3: receive from one of two selected line inputs
// RL4: deserialise, frame on comma, decode, flag errors
// RL5: rebuild host characters, queue them, present to host
// RL6: coder bypass passes pre-encoded characters unchanged
// RL7: queue bypass locks transfers to character slots
// RL8: each queue holds 256 characters, both bypassed by one pin
// RL9: raw mode low data bits are code low bits
// RL10: port is a queue or a pipeline register
// RL11: pattern generator and checker test the link
// RL12: flag toggles force K28.0 or K28.3 past queue
// RL13: host holds data stable around its write edge
`timescale 1ns/1ps
module sl8b_xcvr_top #(
  parameter int unsigned DEPTH = sl8b_pkg::QUEUE_DEPTH
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // mode pins
  input wire logic coder_bypass_n_i,
  input wire logic queue_bypass_n_i,
  input wire logic byte8_i,
  input wire logic bist_en_i,
  input wire logic rx_sel_i,
  // transmit host port
  input wire logic tx_write_clock_i,
  input wire sl8b_pkg::sl8b_char_t tx_char_in_i,
  input wire logic tx_flag_toggle_i,
  output logic tx_full_o,
  // receive host port
  input wire logic rx_read_clock_i,
  output sl8b_pkg::sl8b_char_t rx_char_o,
  output logic rx_valid_o,
  output logic rx_empty_o,
  output logic rx_flag_mirror_o,
  output logic rx_code_err_o,
  output logic rx_lock_o,
  output logic bist_err_o,
  // serial line
  output logic tx_serial_o,
  input wire logic rx_line_a_i,
  input wire logic rx_line_b_i
);
  import sl8b_pkg::*;
  localparam int unsigned SYNC_W = 10 + PORT_BITS; // all input pins except ref_clk_i and nrst_i
  // every pin except ref_clk_i and nrst_i passes two flops before use
  logic [SYNC_W-1:0] pin_raw, sync1_q, sync2_q;
  assign pin_raw = {coder_bypass_n_i, queue_bypass_n_i, byte8_i, bist_en_i, rx_sel_i,
                    tx_write_clock_i, rx_read_clock_i, tx_flag_toggle_i, rx_line_a_i,
                    rx_line_b_i, tx_char_in_i};
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
    end
  end
  logic coder_on, queue_on, byte8, bist_on, rx_sel, wclk, rclk, flag_lvl;
  logic line_a, line_b;
  sl8b_char_t tx_data;
  assign {coder_on, queue_on, byte8, bist_on, rx_sel, wclk, rclk, flag_lvl, line_a, line_b,
          tx_data} = sync2_q;
  // host strobe edges
  logic [1:0] edge_q;
  logic wclk_rise, rclk_rise;
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      edge_q <= 2'h0;
    end else begin
      edge_q <= {wclk, rclk};
    end
  end
  assign wclk_rise = wclk && !edge_q[1];
  assign rclk_rise = rclk && !edge_q[0];
  // queues, both bypassed together by one pin
  sl8b_q_if #(.W(PORT_BITS)) txq ();
  sl8b_q_if #(.W(PORT_BITS)) rxq ();
  sl8b_fifo #(.W(PORT_BITS), .DEPTH(DEPTH)) u_txq ( // RL8
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .q(txq.queue)
  );
  sl8b_fifo #(.W(PORT_BITS), .DEPTH(DEPTH)) u_rxq ( // RL8
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .q(rxq.queue)
  );
  // host write into the transmit queue, width per mode
  assign txq.push = queue_on && wclk_rise; // RL1 RL13
  assign txq.wdata = (coder_on && byte8) ? {4'h0, tx_data[7:0]} : tx_data; // RL1
  // character slot divider
  logic [3:0] bit_cnt_q, bit_cnt_d;
  logic char_en;
  assign char_en = (bit_cnt_q == 4'(CHAR_BITS - 1));
  // transmit state registers, read by the slot selection below
  logic rd_q, rd_d, flag_sent_q, flag_sent_d;
  logic [7:0] lfsr_q, lfsr_d;
  logic pad_q, pad_d; // one idle slot owed after the pattern stops
  // transmit source selection for the next slot
  logic flag_force, lfsr_step, pad_slot, tx_pop, has_src, sel_raw, sel_k;
  logic [7:0] sel_data;
  sl8b_char_t src;
  always_comb begin
    flag_force = 1'b0;
    lfsr_step = 1'b0;
    pad_slot = 1'b0;
    tx_pop = 1'b0;
    has_src = 1'b0;
    src = '0;
    sel_k = 1'b1;
    sel_data = K28_5_BYTE; // idle pad when nothing else
    if (coder_on && queue_on && flag_lvl != flag_sent_q) begin
      flag_force = 1'b1; // RL12
      sel_data = flag_lvl ? K28_0_BYTE : K28_3_BYTE; // RL12
    end else if (bist_on) begin
      lfsr_step = 1'b1; // RL11
      sel_k = 1'b0;
      sel_data = lfsr_q;
    end else if (pad_q) begin
      // one K28.5 after the pattern tells the far end the pattern is over
      pad_slot = 1'b1; // RL11
    end else if (!queue_on) begin
      has_src = 1'b1; // RL7 RL10
      src = tx_data;
    end else if (!txq.empty) begin
      has_src = 1'b1;
      tx_pop = 1'b1;
      src = txq.rdata;
    end
    sel_raw = has_src && !coder_on; // RL6
    if (has_src && coder_on) begin
      sel_data = src[7:0];
      sel_k = !byte8 && src[POS_K];
    end
  end
  assign txq.pop = char_en && tx_pop; // RL2
  // coder, shared by both directions
  logic [9:0] enc_code, tx_code, rx_sh_d;
  logic enc_rd, dec_k, dec_err;
  logic [7:0] dec_data;
  sl8b_codec u_codec (
    .enc_data_i(sel_data),
    .enc_k_i(sel_k),
    .enc_rd_i(rd_q),
    .enc_code_o(enc_code),
    .enc_rd_o(enc_rd),
    .dec_code_i(rx_sh_d),
    .dec_data_o(dec_data),
    .dec_k_o(dec_k),
    .dec_err_o(dec_err)
  );
  assign tx_code = sel_raw ? src[9:0] : enc_code; // RL6 RL9
  // transmit state next values
  logic [9:0] shift_q, shift_d;
  always_comb begin
    bit_cnt_d = char_en ? 4'h0 : bit_cnt_q + 4'h1;
    shift_d = char_en ? tx_code : {shift_q[8:0], 1'b0}; // RL2
    rd_d = (char_en && !sel_raw) ? enc_rd : rd_q;
    flag_sent_d = (char_en && flag_force) ? flag_lvl : flag_sent_q; // RL12
    pad_d = bist_on || (pad_q && !(char_en && pad_slot)); // RL11
    lfsr_d = lfsr_q;
    if (char_en && lfsr_step) begin
      lfsr_d = {lfsr_q[6:0], 1'b0} ^ (lfsr_q[7] ? LFSR_POLY : 8'h00); // RL11
    end
  end
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bit_cnt_q <= 4'h0;
      shift_q <= '0;
      rd_q <= RD_RESET;
      flag_sent_q <= 1'b0;
      lfsr_q <= BIST_SEED;
      pad_q <= 1'b0;
    end else begin
      bit_cnt_q <= bit_cnt_d;
      shift_q <= shift_d;
      rd_q <= rd_d;
      flag_sent_q <= flag_sent_d;
      lfsr_q <= lfsr_d;
      pad_q <= pad_d;
    end
  end
  assign tx_serial_o = shift_q[9]; // msb first
  // receive framing: one bit per clock from the selected line
  logic [9:0] rx_sh_q;
  logic [3:0] rx_cnt_q, rx_cnt_d;
  sl8b_align_e align_q, align_d;
  logic comma, rx_done;
  always_comb begin
    rx_sh_d = {rx_sh_q[8:0], rx_sel ? line_b : line_a}; // RL3
    comma = (rx_sh_d[9:3] == COMMA_NEG) || (rx_sh_d[9:3] == COMMA_POS); // RL4
    rx_done = comma || (align_q == SL8B_LOCK && rx_cnt_q == 4'(CHAR_BITS - 1)); // RL4
    rx_cnt_d = (rx_done || align_q == SL8B_HUNT) ? 4'h0 : rx_cnt_q + 4'h1;
    case (align_q)
      SL8B_HUNT: align_d = comma ? SL8B_LOCK : SL8B_HUNT;
      SL8B_LOCK: align_d = SL8B_LOCK;
      default: align_d = SL8B_HUNT;
    endcase
  end
  // receive word build and delivery
  sl8b_char_t rx_word, rx_char_d;
  logic special, deliver, mirror_d, valid_d, cerr_d, lock_d;
  logic bist_seen_q, bist_seen_d, bist_err_d;
  logic quiet_q, quiet_d; // pattern characters still draining off the line
  logic [7:0] bist_exp_q, bist_exp_d;
  always_comb begin
    if (!coder_on) begin
      rx_word = {2'h0, rx_sh_d}; // RL6
    end else if (byte8) begin
      rx_word = {4'h0, dec_data}; // RL5
    end else begin
      rx_word = {2'h0, dec_err, dec_k, dec_data}; // RL5
    end
    special = coder_on && dec_k &&
              (dec_data == K28_0_BYTE || dec_data == K28_3_BYTE || dec_data == K28_5_BYTE);
    // pattern in flight when self-test stops is dropped up to the next K character
    quiet_d = bist_on || (quiet_q && !(rx_done && dec_k)); // RL11
    deliver = rx_done && !special && !bist_on && !quiet_q;
    mirror_d = rx_flag_mirror_o;
    if (rx_done && coder_on && dec_k && dec_data == K28_0_BYTE) begin
      mirror_d = 1'b1; // RL12
    end else if (rx_done && coder_on && dec_k && dec_data == K28_3_BYTE) begin
      mirror_d = 1'b0; // RL12
    end
    rx_char_d = rx_char_o;
    valid_d = 1'b0;
    if (!queue_on && deliver) begin
      rx_char_d = rx_word; // RL7 RL10
      valid_d = 1'b1;
    end else if (queue_on && rclk_rise && !rxq.empty) begin
      rx_char_d = rxq.rdata; // RL5
      valid_d = 1'b1;
    end
    cerr_d = rx_done && coder_on && dec_err; // RL4
    lock_d = (align_d == SL8B_LOCK);
    bist_seen_d = bist_seen_q;
    bist_exp_d = bist_exp_q;
    bist_err_d = bist_err_o;
    if (!bist_on) begin
      bist_seen_d = 1'b0;
      bist_err_d = 1'b0;
    end else if (rx_done && !dec_k) begin
      bist_seen_d = 1'b1; // RL11
      bist_exp_d = {dec_data[6:0], 1'b0} ^ (dec_data[7] ? LFSR_POLY : 8'h00);
      if (dec_err || (bist_seen_q && dec_data != bist_exp_q)) begin
        bist_err_d = 1'b1; // RL11
      end
    end
  end
  assign rxq.push = queue_on && deliver; // RL5 RL8
  assign rxq.wdata = rx_word;
  assign rxq.pop = queue_on && rclk_rise;
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_sh_q <= '0;
      rx_cnt_q <= 4'h0;
      align_q <= SL8B_HUNT;
      rx_char_o <= '0;
      rx_valid_o <= 1'b0;
      rx_flag_mirror_o <= 1'b0;
      rx_code_err_o <= 1'b0;
      rx_lock_o <= 1'b0;
      bist_seen_q <= 1'b0;
      quiet_q <= 1'b0;
      bist_exp_q <= 8'h00;
      bist_err_o <= 1'b0;
      tx_full_o <= 1'b0;
      rx_empty_o <= 1'b1;
    end else begin
      rx_sh_q <= rx_sh_d;
      rx_cnt_q <= rx_cnt_d;
      align_q <= align_d;
      rx_char_o <= rx_char_d;
      rx_valid_o <= valid_d;
      rx_flag_mirror_o <= mirror_d;
      rx_code_err_o <= cerr_d;
      rx_lock_o <= lock_d;
      bist_seen_q <= bist_seen_d;
      quiet_q <= quiet_d;
      bist_exp_q <= bist_exp_d;
      bist_err_o <= bist_err_d;
      tx_full_o <= txq.full;
      rx_empty_o <= rxq.empty;
    end
  end
  // checks
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!nrst_i);
  sequence s_first_bit;
    tx_serial_o == $past(tx_code[9]);
  endsequence
  sequence s_last_bit;
    tx_serial_o == $past(tx_code[0], 10);
  endsequence
  a_serial_bit_order: assert property (char_en |=> s_first_bit ##9 s_last_bit) // RL2
    else $error("serial bits not sent msb first over ten clocks");
  a_char_slot_cadence: assert property ( // RL2
    char_en |=> !char_en [*8] ##1 !char_en ##1 char_en)
    else $error("character slot not every ten clocks");
  a_flag_rise_code: assert property ( // RL12
    char_en && flag_force && flag_lvl |=> shift_q == K28_0_NEG || shift_q == K28_0_POS)
    else $error("flag rise did not send K28.0");
  a_flag_fall_code: assert property ( // RL12
    char_en && flag_force && !flag_lvl |=> shift_q == K28_3_NEG || shift_q == K28_3_POS)
    else $error("flag fall did not send K28.3");
  a_tx_queue_take: assert property (wclk_rise && queue_on && !txq.full |=> !txq.empty) // RL1
    else $error("host character not queued");
  a_raw_pass: assert property (char_en && sel_raw |=> shift_q == $past(src[9:0])) // RL6
    else $error("raw character altered");
  a_rx_mirror_set: assert property ( // RL12
    rx_done && coder_on && dec_k && dec_data == K28_0_BYTE |=> rx_flag_mirror_o)
    else $error("mirror flag not raised");
  a_rx_bypass_out: assert property ( // RL7
    deliver && !queue_on |=> rx_valid_o && rx_char_o == $past(rx_word))
    else $error("bypassed receive character not presented");
  a_rx_frame_gate: assert property (rx_done && !comma |-> $past(rx_done, 10)) // RL4
    else $error("character boundary off the ten-clock cadence");
  a_bist_mismatch: assert property ( // RL11
    bist_on && rx_done && !dec_k && bist_seen_q && dec_data != bist_exp_q |=> bist_err_o)
    else $error("pattern mismatch not flagged");
endmodule // sl8b_xcvr_top

// >>> rtl/sl8b_pkg.sv
// constants, tables and types for the serial link transceiver
// assumes a single bit-rate clock; one line character spans CHAR_BITS clocks
package sl8b_pkg;
  localparam int unsigned CHAR_BITS = 10; // line bits per character
  localparam int unsigned PORT_BITS = 12; // host port width
  localparam int unsigned QUEUE_DEPTH = 256; // characters per queue
  localparam int unsigned POS_K = 8; // control flag in a 10-bit host char
  localparam int unsigned POS_ERR = 9; // code error in a 10-bit rx char
  localparam logic RD_RESET = 1'b0; // running disparity starts negative
  localparam logic [7:0] BIST_SEED = 8'h01; // pattern start value
  localparam logic [7:0] LFSR_POLY = 8'h1d; // x^8+x^4+x^3+x^2+1
  localparam logic [7:0] K28_0_BYTE = 8'h1c; // flag rise marker
  localparam logic [7:0] K28_3_BYTE = 8'h7c; // flag fall marker
  localparam logic [7:0] K28_5_BYTE = 8'hbc; // idle pad
  localparam logic [9:0] K28_0_NEG = 10'h0f4;
  localparam logic [9:0] K28_0_POS = 10'h30b;
  localparam logic [9:0] K28_3_NEG = 10'h0f3;
  localparam logic [9:0] K28_3_POS = 10'h30c;
  localparam logic [6:0] COMMA_NEG = 7'h1f; // 0011111
  localparam logic [6:0] COMMA_POS = 7'h60; // 1100000
  localparam logic [5:0] K28_6B = 6'h0f; // six-bit part of K28.y
  localparam logic [3:0] A7_4B = 4'h7; // alternate x.7 form
  // six-bit sub-blocks for negative disparity, abcdei, a first
  localparam logic [5:0] TAB6 [32] = '{
    6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
    6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
  // four-bit sub-blocks for negative disparity, fghj
  localparam logic [3:0] TAB4 [8] = '{
    4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};
  typedef logic [PORT_BITS-1:0] sl8b_char_t; // host character
  typedef enum logic [1:0] {
    SL8B_HUNT = 2'b01, // looking for a comma
    SL8B_LOCK = 2'b10 // character boundary known
  } sl8b_align_e;
endpackage

// >>> rtl/sl8b_q_if.sv
// queue port bundle between the transceiver core and its queues
// assumes the queue and its user share one clock
`timescale 1ns/1ps
interface sl8b_q_if #(parameter int unsigned W = 12);
  logic push; // write request
  logic pop; // read request
  logic full; // no room
  logic empty; // nothing stored
  logic [W-1:0] wdata; // write word
  logic [W-1:0] rdata; // head word, show-ahead
  modport queue (input push, pop, wdata, output full, empty, rdata);
  modport user (output push, pop, wdata, input full, empty, rdata);
endinterface

// >>> rtl/sl8b_fifo.sv
// synchronous show-ahead queue in flip-flops
// assumes push and pop come from logic on the same clock
`timescale 1ns/1ps
module sl8b_fifo #(
  parameter int unsigned W = 12,
  parameter int unsigned DEPTH = 256
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // queue port
  sl8b_q_if.queue q
);
  localparam int unsigned AW = $clog2(DEPTH);
  // refuse depths the pointer wrap cannot serve
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("queue depth must be a power of two");
  end
  logic [W-1:0] mem_q [DEPTH]; // storage, indexed by pointer
  logic [AW:0] wp_q, wp_d; // write pointer with wrap bit
  logic [AW:0] rp_q, rp_d; // read pointer with wrap bit
  logic do_push, do_pop;
  // refused pushes and pops leave the pointers alone
  always_comb begin
    do_push = q.push && !q.full;
    do_pop = q.pop && !q.empty;
    wp_d = do_push ? wp_q + 1'b1 : wp_q;
    rp_d = do_pop ? rp_q + 1'b1 : rp_q;
  end
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
  end
  // storage has no reset, only written entries are ever read
  always_ff @(posedge ref_clk_i) begin
    if (do_push) begin
      mem_q[wp_q[AW-1:0]] <= q.wdata;
    end
  end
  assign q.empty = (wp_q == rp_q);
  assign q.full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  assign q.rdata = mem_q[rp_q[AW-1:0]];
endmodule // sl8b_fifo

// >>> rtl/sl8b_codec.sv
// combinational 8b/10b encoder and decoder, data and K28.y only
// assumes the caller holds running disparity between characters
`timescale 1ns/1ps
module sl8b_codec (
  // encoder side
  input wire logic [7:0] enc_data_i,
  input wire logic enc_k_i,
  input wire logic enc_rd_i,
  output logic [9:0] enc_code_o,
  output logic enc_rd_o,
  // decoder side
  input wire logic [9:0] dec_code_i,
  output logic [7:0] dec_data_o,
  output logic dec_k_o,
  output logic dec_err_o
);
  import sl8b_pkg::*;
  // four-bit sub-block for the disparity left by the six-bit part
  function automatic logic [3:0] enc4(input logic [2:0] y, input logic k,
                                      input logic [4:0] x, input logic rd1);
    logic [3:0] c;
    logic a7;
    logic unb;
    logic inv;
    a7 = (y == 3'h7) && (k || (!rd1 && (x == 5'h11 || x == 5'h12 || x == 5'h14))
         || (rd1 && (x == 5'h0b || x == 5'h0d || x == 5'h0e)));
    c = a7 ? A7_4B : TAB4[y];
    unb = ($countones(c) != 2);
    // K28 flips its balanced forms the other way round
    if (k && !unb && y != 3'h3) begin
      inv = !rd1;
    end else begin
      inv = rd1 && (unb || y == 3'h3);
    end
    return inv ? ~c : c;
  endfunction
  logic [4:0] ex;
  logic [5:0] c6;
  logic [3:0] c4;
  logic u6, rd1;
  // encoder
  always_comb begin
    ex = enc_k_i ? 5'h1c : enc_data_i[4:0];
    c6 = enc_k_i ? K28_6B : TAB6[ex];
    u6 = ($countones(c6) != 3);
    if (enc_rd_i && (u6 || (!enc_k_i && ex == 5'h07))) begin
      c6 = ~c6;
    end
    rd1 = enc_rd_i ^ u6;
    c4 = enc4(enc_data_i[7:5], enc_k_i, ex, rd1);
    enc_code_o = {c6, c4};
    enc_rd_o = rd1 ^ ($countones(c4) != 2);
  end
  logic [5:0] d6;
  logic [4:0] dx;
  logic [2:0] dy;
  logic kk, hit6, hit4;
  // decoder, searches both disparity forms of each sub-block
  always_comb begin
    d6 = dec_code_i[9:4];
    kk = (d6 == K28_6B) || (d6 == ~K28_6B);
    dx = kk ? 5'h1c : 5'h00;
    dy = 3'h0;
    hit6 = kk;
    hit4 = 1'b0;
    for (int i = 0; i < 32; i++) begin
      if (!kk && (TAB6[i] == d6 || (~TAB6[i] == d6 &&
          ($countones(TAB6[i]) != 3 || i == 7)))) begin
        dx = 5'(i);
        hit6 = 1'b1;
      end
    end
    for (int j = 0; j < 8; j++) begin
      for (int r = 0; r < 2; r++) begin
        if (enc4(3'(j), kk, dx, r[0]) == dec_code_i[3:0] &&
            (!kk || r[0] == (d6 == K28_6B))) begin
          dy = 3'(j);
          hit4 = 1'b1;
        end
      end
    end
    dec_data_o = {dy, dx};
    dec_k_o = kk;
    dec_err_o = !(hit6 && hit4);
  end
endmodule // sl8b_codec

// >>> verification/sl8b_remote.sv
// remote end of the serial line: loops our transmit line back to us
// assumes both ends run one bit per ref_clk_i cycle, frequency-locked
`timescale 1ns/1ps
module sl8b_remote (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // control from the bench
  input wire logic sel_b_i,
  input wire logic jam_i,
  // serial lines
  input wire logic line_in_i,
  output logic line_a_o,
  output logic line_b_o
);
  logic bit_q; // looped-back bit, one clock late
  logic noise_q; // filler for the idle line
  // loop back, or force ones while jammed to break a character
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bit_q <= 1'b0;
      noise_q <= 1'b0;
    end else begin
      bit_q <= jam_i ? 1'b1 : line_in_i;
      noise_q <= ~noise_q;
    end
  end
  // unused line toggles every cycle so a stale value never looks valid
  assign line_a_o = sel_b_i ? noise_q : bit_q;
  assign line_b_o = sel_b_i ? bit_q : noise_q;
endmodule // sl8b_remote

// >>> verification/tb.sv
// self-checking bench for the serial link transceiver core
// assumes the remote model loops the line back, queues shrunk to QD
`timescale 1ns/1ps
module tb;
  import sl8b_pkg::*;
  localparam int unsigned QD = 4; // short queues keep fill tests quick
  localparam int TMO = 6000; // ceiling on clock cycles
  // clock, reset and pins
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic coder_bypass_n_i = 1'b1;
  logic queue_bypass_n_i = 1'b1;
  logic byte8_i = 1'b1;
  logic bist_en_i = 1'b0;
  logic rx_sel_i = 1'b0;
  logic tx_write_clock_i = 1'b0;
  sl8b_char_t tx_char_in_i = '0;
  logic tx_flag_toggle_i = 1'b0;
  logic rx_read_clock_i = 1'b0;
  logic sel_b = 1'b0; // remote loops back on line b
  logic jam = 1'b0; // remote forces ones
  logic tx_full_o, rx_valid_o, rx_empty_o, rx_flag_mirror_o, rx_code_err_o;
  logic rx_lock_o, bist_err_o, tx_serial_o, line_a, line_b;
  sl8b_char_t rx_char_o;
  logic [9:0] sh = '0; // last ten line bits sent
  logic [11:0] exp_q [$]; // model: characters in flight
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int seed = 32'hd773;

  always #10 ref_clk_i = ~ref_clk_i;

  sl8b_xcvr_top #(.DEPTH(QD)) u_dut (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
    .coder_bypass_n_i(coder_bypass_n_i), .queue_bypass_n_i(queue_bypass_n_i),
    .byte8_i(byte8_i), .bist_en_i(bist_en_i), .rx_sel_i(rx_sel_i),
    .tx_write_clock_i(tx_write_clock_i), .tx_char_in_i(tx_char_in_i),
    .tx_flag_toggle_i(tx_flag_toggle_i), .tx_full_o(tx_full_o),
    .rx_read_clock_i(rx_read_clock_i), .rx_char_o(rx_char_o),
    .rx_valid_o(rx_valid_o), .rx_empty_o(rx_empty_o),
    .rx_flag_mirror_o(rx_flag_mirror_o), .rx_code_err_o(rx_code_err_o),
    .rx_lock_o(rx_lock_o), .bist_err_o(bist_err_o), .tx_serial_o(tx_serial_o),
    .rx_line_a_i(line_a), .rx_line_b_i(line_b));

  sl8b_remote u_remote (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .sel_b_i(sel_b), .jam_i(jam),
    .line_in_i(tx_serial_o), .line_a_o(line_a), .line_b_o(line_b));

  // watch the line: serial order is msb first
  always @(posedge ref_clk_i) begin
    sh <= {sh[8:0], tx_serial_o};
  end

  // hang guard
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == TMO) begin
      bad_count++;
      results();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask

  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // selects which output a wait watches
  function automatic logic pick(input int w);
    case (w)
      0: return rx_lock_o;
      1: return rx_flag_mirror_o;
      2: return rx_code_err_o;
      default: return rx_valid_o;
    endcase
  endfunction

  task automatic await(input int w, input logic v, input int lim, output logic hit);
    hit = 1'b0;
    for (int i = 0; i < lim && !hit; i++) begin
      tick(1);
      hit = (pick(w) === v);
    end
  endtask

  // one host write: data settles before the strobe and outlives it
  task automatic put(input logic [11:0] c);
    tx_char_in_i = c;
    tick(4);
    tx_write_clock_i = 1'b1;
    tick(4);
    tx_write_clock_i = 1'b0;
  endtask

  // one host read, compared with the model's head
  task automatic get(input logic [11:0] e);
    logic hit;
    rx_read_clock_i = 1'b1;
    await(3, 1'b1, 12, hit);
    check({hit, rx_char_o[10:0]}, {1'b1, e[10:0]});
    tick(3);
    rx_read_clock_i = 1'b0;
    tick(4);
  endtask

  task automatic results();
    $display("compares %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    logic hit;
    logic [11:0] v;
    logic [9:0] x;
    tick(2);
    v = {4'h0, rx_empty_o, rx_valid_o, tx_full_o, rx_lock_o, rx_flag_mirror_o,
         bist_err_o, tx_serial_o, rx_code_err_o};
    check(v, 12'h080);
    check(rx_char_o, 12'h000);
    tick(2);
    nrst_i = 1'b1;
    $display("test reset done");
    // idle pads carry commas, so the looped line must frame
    await(0, 1'b1, 400, hit);
    check({11'h0, hit}, 12'h001);
    $display("test lock done");
    // pattern holds the queue, fill past full, then drain in order
    for (int m = 0; m < 2; m++) begin
      byte8_i = (m == 0);
      bist_en_i = 1'b1;
      tick(60);
      for (int i = 0; i < QD + 2; i++) begin
        v = {4'h0, 8'($random(seed))};
        if (m == 1 && i == 0) v = 12'h13c; // K28.1 as a 10-bit control character
        if (i < QD) exp_q.push_back(v);
        put(v);
      end
      tick(4);
      check({11'h0, tx_full_o}, 12'h001);
      check({11'h0, bist_err_o}, 12'h000);
      bist_en_i = 1'b0;
      tick(10 * QD + 80);
      while (exp_q.size() > 0) get(exp_q.pop_front());
      rx_read_clock_i = 1'b1;
      await(3, 1'b1, 12, hit);
      check({11'h0, hit}, 12'h000);
      check({11'h0, rx_empty_o}, 12'h001);
      rx_read_clock_i = 1'b0;
      tick(4);
      $display("test queue mode %0d done", m);
    end
    // flag toggles cross the link on either line input
    for (int s = 0; s < 2; s++) begin
      sel_b = s[0];
      rx_sel_i = s[0];
      tick(40);
      for (int f = 1; f >= 0; f--) begin
        tx_flag_toggle_i = f[0];
        await(1, f[0], 100, hit);
        check({11'h0, hit}, 12'h001);
      end
    end
    $display("test flag done");
    // raw codes, queues bypassed: pins sampled every slot
    coder_bypass_n_i = 1'b0;
    queue_bypass_n_i = 1'b0;
    for (int i = 0; i < 3; i++) begin
      // balanced sub-blocks only, so no mix of them can hold a comma
      do x = {TAB6[$random(seed) & 31], TAB4[$random(seed) & 7]};
      while ($countones(x[9:4]) != 3 || $countones(x[3:0]) != 2);
      tx_char_in_i = {2'($random(seed)), x};
      hit = 1'b0;
      for (int k = 0; k < 60 && !hit; k++) begin
        tick(1);
        hit = (sh === x);
      end
      check({11'h0, hit}, 12'h001);
      hit = 1'b0;
      for (int k = 0; k < 80 && !hit; k++) begin
        tick(1);
        hit = (rx_valid_o === 1'b1) && (rx_char_o[9:0] === x);
      end
      check({11'h0, hit}, 12'h001);
      await(3, 1'b1, 12, hit);
      check({1'b0, hit, rx_char_o[9:0]}, {2'b01, x});
    end
    $display("test raw bypass done");
    // break a character during self-test
    coder_bypass_n_i = 1'b1;
    queue_bypass_n_i = 1'b1;
    bist_en_i = 1'b1;
    tick(80);
    jam = 1'b1;
    tick(12);
    jam = 1'b0;
    await(2, 1'b1, 60, hit);
    check({11'h0, hit}, 12'h001);
    tick(6);
    check({11'h0, bist_err_o}, 12'h001);
    bist_en_i = 1'b0;
    tick(10);
    check({11'h0, bist_err_o}, 12'h000);
    $display("test error done");
    results();
  end
endmodule // tb
